/* hdl/lane_mapper_pkg.sv */
// Shared types and constants of the converter lane sample mapper.
package lane_mapper_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int SAMPLE_W     = 9;
  localparam int NARROW_W     = 8;
  localparam int CHANNELS     = 4;
  localparam int SAMPLES_MAX  = 20;
  localparam int LANES        = 8;
  localparam int LANE_W       = 64;
  localparam int OCT_CNT_W    = 4;

  // ----------------------------------------------------------------
  // Slot layouts
  // ----------------------------------------------------------------
  localparam int PAIR_SLOT_W  = 10;
  localparam int PAIR_SLOTS   = 4;
  localparam int PAIR_LANES   = 2;
  localparam int PAIR_OCTETS  = 5;
  localparam int WIDE_SLOT_W  = 12;
  localparam int WIDE_SLOTS   = 5;
  localparam int WIDE_LANES   = 4;
  localparam int WIDE_OCTETS  = 8;
  localparam int NARROW_LANES = 4;
  localparam int NARROW_OCTS  = 1;
  localparam int NARROW_LSB   = 1;

  // ----------------------------------------------------------------
  // Counters and reset values
  // ----------------------------------------------------------------
  localparam int DROP_W       = 16;
  localparam int BUF_DEPTH    = 2;
  localparam logic [LANES-1:0]  LANE_RST = 8'h00;
  localparam logic [DROP_W-1:0] DROP_RST = 16'h0000;
  localparam logic [DROP_W-1:0] DROP_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_NINE_PAIR,
    FMT_NINE_WIDE,
    FMT_EIGHT_BIT,
    FMT_UNUSED
  } link_format_select_t;

  typedef enum logic [1:0] {
    CH_SINGLE,
    CH_DUAL,
    CH_QUAD,
    CH_UNUSED
  } chan_mode_t;

  typedef logic [SAMPLE_W-1:0] sample_t;

  typedef struct packed {
    sample_t [CHANNELS-1:0][SAMPLES_MAX-1:0] chan;
  } sample_block_t;

  typedef struct packed {
    logic [LANES-1:0][LANE_W-1:0] lane;
    logic [OCT_CNT_W-1:0]         octets;
  } lane_frame_t;

endpackage : lane_mapper_pkg

/* hdl/lane_frame_buffer.sv */
// Two-entry valid/ready buffer holding mapped lane frames.
module lane_frame_buffer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [W-1:0] mem [lane_mapper_pkg::BUF_DEPTH];
  logic         wrPtr_q;
  logic         rdPtr_q;
  logic [1:0]   count_q;
  logic         push;
  logic         pop;

  assign inReady  = ce && (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = ce && outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (ce) begin
      if (push) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : lane_frame_buffer

/* hdl/adc_lane_sample_mapper.sv */
// Maps converter channel samples onto the eight transport lanes.
//
// Overview of operation
// RL1 - A paired-format lane frame is five octets: four slots, each a sample and one zero bit.
// RL2 - In the paired format a channel owns a lane pair: even samples low lane, odd ones high.
// RL3 - A wide lane frame is eight octets of five 12-bit slots; lane k takes samples k + 4j.
// RL4 - The eight-bit format serves single or dual channel use only and is refused in quad use.
// RL5 - In the eight-bit format a lane holds the eight most significant bits of one sample, A on lanes 0-3 and B on lanes 4-7.
// RL6 - Pads and frame tails are zero, and every sample is placed most significant bit first.
//
// All inputs come from logic on the frame clock, so none passes a synchroniser here.
module adc_lane_sample_mapper (
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  input  wire logic                                 ce,
  input  wire lane_mapper_pkg::link_format_select_t linkFormatSelect,
  input  wire lane_mapper_pkg::chan_mode_t          channelMode,
  input  wire logic                                 sampleValid,
  output logic                                      sampleReady,
  input  wire lane_mapper_pkg::sample_block_t       samples,
  output logic                                      frameValid,
  input  wire logic                                 frameReady,
  output lane_mapper_pkg::lane_frame_t              laneFrame,
  output logic [lane_mapper_pkg::LANES-1:0]         laneActive,
  output logic                                      formatRejected,
  output logic [lane_mapper_pkg::DROP_W-1:0]        droppedFrames
);

  // ----------------------------------------------------------------
  // Configuration helpers
  // ----------------------------------------------------------------

  function automatic int chan_count(input lane_mapper_pkg::chan_mode_t m);
    case (m)
      lane_mapper_pkg::CH_SINGLE: chan_count = 1;
      lane_mapper_pkg::CH_DUAL:   chan_count = 2;
      lane_mapper_pkg::CH_QUAD:   chan_count = 4;
      default:                    chan_count = 0;
    endcase
  endfunction : chan_count

  // The dual/single-only formats spread one channel over four lanes, so eight lanes
  // cannot carry four channels and quad use is refused for both of them.
  function automatic logic fmt_allowed(
    input lane_mapper_pkg::link_format_select_t f,
    input lane_mapper_pkg::chan_mode_t          m
  );
    case (f)
      lane_mapper_pkg::FMT_NINE_PAIR: fmt_allowed = (chan_count(m) != 0);
      lane_mapper_pkg::FMT_NINE_WIDE: fmt_allowed = (chan_count(m) != 0) &&
                                                    (m != lane_mapper_pkg::CH_QUAD); // [RL3]
      lane_mapper_pkg::FMT_EIGHT_BIT: fmt_allowed = (chan_count(m) != 0) &&
                                                    (m != lane_mapper_pkg::CH_QUAD); // [RL4]
      default:                        fmt_allowed = 1'b0;
    endcase
  endfunction : fmt_allowed

  // Channel that feeds a lane, per format.
  function automatic int lane_chan(
    input lane_mapper_pkg::link_format_select_t f,
    input int                                   l
  );
    case (f)
      lane_mapper_pkg::FMT_NINE_PAIR: lane_chan = l / lane_mapper_pkg::PAIR_LANES;
      lane_mapper_pkg::FMT_NINE_WIDE: lane_chan = l / lane_mapper_pkg::WIDE_LANES;
      lane_mapper_pkg::FMT_EIGHT_BIT: lane_chan = l / lane_mapper_pkg::NARROW_LANES;
      default:                        lane_chan = lane_mapper_pkg::CHANNELS;
    endcase
  endfunction : lane_chan

  function automatic logic [lane_mapper_pkg::LANES-1:0] active_lanes(
    input lane_mapper_pkg::link_format_select_t f,
    input lane_mapper_pkg::chan_mode_t          m
  );
    active_lanes = '0;
    for (int l = 0; l < lane_mapper_pkg::LANES; l++) begin
      active_lanes[l] = fmt_allowed(f, m) && (lane_chan(f, l) < chan_count(m));
    end
  endfunction : active_lanes

  // ----------------------------------------------------------------
  // Lane placement
  // ----------------------------------------------------------------

  // The whole frame is built in one cycle; the cost is a wide mux tree, which is
  // acceptable at the frame clock and keeps latency fixed at one buffer stage.
  function automatic lane_mapper_pkg::lane_frame_t map_frame(
    input lane_mapper_pkg::link_format_select_t f,
    input lane_mapper_pkg::chan_mode_t          m,
    input lane_mapper_pkg::sample_block_t       b
  );
    logic [lane_mapper_pkg::LANES-1:0] act;
    int                                ch;
    int                                pos;
    act       = active_lanes(f, m);
    ch        = 0;
    pos       = 0;
    map_frame = '0; // [RL6]
    for (int l = 0; l < lane_mapper_pkg::LANES; l++) begin
      ch = lane_chan(f, l);
      if (act[l]) begin
        case (f)
          lane_mapper_pkg::FMT_NINE_PAIR: begin
            for (int j = 0; j < lane_mapper_pkg::PAIR_SLOTS; j++) begin
              pos = lane_mapper_pkg::LANE_W - 1 - j * lane_mapper_pkg::PAIR_SLOT_W;
              map_frame.lane[l][pos -: lane_mapper_pkg::SAMPLE_W] =
                b.chan[ch][j * lane_mapper_pkg::PAIR_LANES +
                           l % lane_mapper_pkg::PAIR_LANES]; // [RL1] [RL2]
            end
          end
          lane_mapper_pkg::FMT_NINE_WIDE: begin
            for (int j = 0; j < lane_mapper_pkg::WIDE_SLOTS; j++) begin
              pos = lane_mapper_pkg::LANE_W - 1 - j * lane_mapper_pkg::WIDE_SLOT_W;
              map_frame.lane[l][pos -: lane_mapper_pkg::SAMPLE_W] =
                b.chan[ch][l % lane_mapper_pkg::WIDE_LANES +
                           j * lane_mapper_pkg::WIDE_LANES]; // [RL3]
            end
          end
          lane_mapper_pkg::FMT_EIGHT_BIT: begin
            map_frame.lane[l][lane_mapper_pkg::LANE_W - 1 -: lane_mapper_pkg::NARROW_W] =
              b.chan[ch][l % lane_mapper_pkg::NARROW_LANES]
                [lane_mapper_pkg::SAMPLE_W - 1 : lane_mapper_pkg::NARROW_LSB]; // [RL5]
          end
          default: begin
            map_frame.lane[l] = '0;
          end
        endcase
      end
    end
    case (f)
      lane_mapper_pkg::FMT_NINE_PAIR:
        map_frame.octets = lane_mapper_pkg::OCT_CNT_W'(lane_mapper_pkg::PAIR_OCTETS);
      lane_mapper_pkg::FMT_NINE_WIDE:
        map_frame.octets = lane_mapper_pkg::OCT_CNT_W'(lane_mapper_pkg::WIDE_OCTETS);
      lane_mapper_pkg::FMT_EIGHT_BIT:
        map_frame.octets = lane_mapper_pkg::OCT_CNT_W'(lane_mapper_pkg::NARROW_OCTS);
      default:
        map_frame.octets = '0;
    endcase
  endfunction : map_frame

  // ----------------------------------------------------------------
  // Acceptance and refusal
  // ----------------------------------------------------------------

  logic                        rejectNow;
  logic                        bufInReady;
  logic                        bufPush;
  logic                        dropNow;
  lane_mapper_pkg::lane_frame_t mapped;
  logic [lane_mapper_pkg::LANES-1:0]  laneActive_q;
  logic [lane_mapper_pkg::LANES-1:0]  activeNow;
  logic                               rejected_q;
  logic [lane_mapper_pkg::DROP_W-1:0] dropped_q;

  assign rejectNow = !fmt_allowed(linkFormatSelect, channelMode); // [RL4]
  assign mapped    = map_frame(linkFormatSelect, channelMode, samples);
  assign activeNow = active_lanes(linkFormatSelect, channelMode); // [RL2] [RL5]

  // A refused block is taken and thrown away rather than stalled, so a source
  // left running under a bad setting cannot hang the upstream pipeline.
  assign sampleReady = ce && (rejectNow || bufInReady); // [RL4]
  assign bufPush     = sampleValid && !rejectNow;
  assign dropNow     = ce && sampleValid && rejectNow;

  // ----------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------

  // Both status flags lag the configuration by one edge; a block is always judged
  // by the configuration that stands beside it, so the lag never misroutes data.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rejected_q <= 1'b0;
    end else if (ce) begin
      rejected_q <= rejectNow; // [RL4]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      laneActive_q <= lane_mapper_pkg::LANE_RST;
    end else if (ce) begin
      laneActive_q <= activeNow; // [RL2] [RL5]
    end
  end

  // Saturates so that a long misconfiguration never wraps back to a small count.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dropped_q <= lane_mapper_pkg::DROP_RST;
    end else if (dropNow && (dropped_q != lane_mapper_pkg::DROP_MAX)) begin
      dropped_q <= dropped_q + 1'b1;
    end
  end

  assign formatRejected = rejected_q;
  assign laneActive     = laneActive_q;
  assign droppedFrames  = dropped_q;

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------

  // With the receiver stalled two frames wait here and sampleReady then falls,
  // so a mapped frame is never overwritten or lost.
  lane_frame_buffer #(
    .W ($bits(lane_mapper_pkg::lane_frame_t))
  ) u_buffer (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .inValid  (bufPush),
    .inReady  (bufInReady),
    .inData   (mapped),
    .outValid (frameValid),
    .outReady (frameReady),
    .outData  (laneFrame)
  );

endmodule : adc_lane_sample_mapper

/* verif/lane_mapper_sva.sv */
// Port checker of the lane sample mapper.
module lane_mapper_sva (
  input wire logic                                 clk,
  input wire logic                                 rstn,
  input wire logic                                 ce,
  input wire lane_mapper_pkg::link_format_select_t linkFormatSelect,
  input wire lane_mapper_pkg::chan_mode_t          channelMode,
  input wire logic                                 sampleValid,
  input wire logic                                 sampleReady,
  input wire logic                                 frameValid,
  input wire logic                                 frameReady,
  input wire lane_mapper_pkg::lane_frame_t         laneFrame,
  input wire logic [7:0]                           laneActive,
  input wire logic                                 formatRejected,
  input wire logic [15:0]                          droppedFrames
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bad;
  logic take;
  assign bad = (linkFormatSelect == 2'h3) || (channelMode == 2'h3)
             || (channelMode == 2'h2 && linkFormatSelect != 2'h0);
  assign take = ce && sampleValid && sampleReady;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_drop_count: assert property (
    take && bad && droppedFrames != 16'hFFFF |=> droppedFrames == $past(droppedFrames) + 16'h0001)
    else $error("refused block not counted");
  chk_reject_flag: assert property (ce |=> formatRejected == $past(bad))
    else $error("reject flag wrong");
  chk_no_output: assert property (take && bad && !frameValid |=> !frameValid)
    else $error("refused block produced a frame");
  chk_frame_next: assert property (take && !bad && !frameValid |=> frameValid)
    else $error("frame missing one cycle after block");
  chk_frame_hold: assert property (
    frameValid && !(frameReady && ce) |=> frameValid && $stable(laneFrame))
    else $error("frame changed before taken");
  chk_octet_count: assert property (
    frameValid |-> laneFrame.octets inside {4'h5, 4'h8, 4'h1})
    else $error("bad octet count");
  chk_pad_zero: assert property (
    frameValid && laneFrame.octets == 4'h5 |-> laneFrame.lane[1][54] == 1'b0
    && laneFrame.lane[1][23:0] == 24'h000000) else $error("pad bits not zero");
  chk_tail_zero: assert property (
    frameValid && laneFrame.octets == 4'h8 |-> laneFrame.lane[1][54:52] == 3'h0
    && laneFrame.lane[1][3:0] == 4'h0) else $error("tail bits not zero");
  chk_quad_lanes: assert property (
    ce && channelMode == 2'h2 && linkFormatSelect == 2'h0 |=> laneActive == 8'hFF)
    else $error("quad pair lanes not active");
endmodule : lane_mapper_sva

bind adc_lane_sample_mapper lane_mapper_sva u_sva (.clk(clk), .rstn(rstn), .ce(ce),
  .linkFormatSelect(linkFormatSelect), .channelMode(channelMode),
  .sampleValid(sampleValid), .sampleReady(sampleReady), .frameValid(frameValid),
  .frameReady(frameReady), .laneFrame(laneFrame), .laneActive(laneActive),
  .formatRejected(formatRejected), .droppedFrames(droppedFrames));

/* verif/frame_receiver.sv */
// Behavioural link receiver that takes lane frames and can stall.
module frame_receiver (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         ce,
  input  wire logic                         stall,
  input  wire logic                         frameValid,
  output logic                              frameReady,
  input  wire lane_mapper_pkg::lane_frame_t laneFrame
);
  timeunit 1ns;
  timeprecision 1ns;
  lane_mapper_pkg::lane_frame_t got[$];
  // Ready is registered, so a stall lands one edge late, as a real receiver would.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frameReady <= 1'b0;
    end else begin
      frameReady <= !stall;
      if (ce && frameValid && frameReady) begin
        got.push_back(laneFrame);
      end
    end
  end
endmodule : frame_receiver

/* verif/testbench.sv */
// Self-checking bench of the lane sample mapper.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                                 clk, rstn, ce, sampleValid, sampleReady, stall;
  logic                                 frameValid, frameReady, formatRejected;
  lane_mapper_pkg::link_format_select_t fmt;
  lane_mapper_pkg::chan_mode_t          mode;
  lane_mapper_pkg::sample_block_t       blk;
  lane_mapper_pkg::lane_frame_t         laneFrame;
  logic [7:0]                           laneActive;
  logic [15:0]                          droppedFrames;
  int                                   mismatches, n_tests, cycles;

  adc_lane_sample_mapper uut (.clk(clk), .rstn(rstn), .ce(ce), .linkFormatSelect(fmt),
    .channelMode(mode), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .samples(blk), .frameValid(frameValid), .frameReady(frameReady),
    .laneFrame(laneFrame), .laneActive(laneActive), .formatRejected(formatRejected),
    .droppedFrames(droppedFrames));
  frame_receiver rx (.clk(clk), .rstn(rstn), .ce(ce), .stall(stall),
    .frameValid(frameValid), .frameReady(frameReady), .laneFrame(laneFrame));

  task automatic chk(input logic [515:0] got, input logic [515:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // Expected lane image, worked out slot by slot; unused lanes stay zero.
  function automatic lane_mapper_pkg::lane_frame_t exp_frame(input int f, input int m);
    lane_mapper_pkg::lane_frame_t e;
    int c;
    e = '0;
    e.octets = (f == 0) ? 4'h5 : (f == 1) ? 4'h8 : 4'h1;
    for (int l = 0; l < 8; l++) begin
      c = (f == 0) ? l / 2 : l / 4;
      if (c < (1 << m)) begin
        for (int j = 0; j < 5; j++) begin
          if (f == 0 && j < 4) e.lane[l][63-10*j -: 9] = blk.chan[c][2*j+l%2];
          if (f == 1) e.lane[l][63-12*j -: 9] = blk.chan[c][l%4+4*j];
        end
        if (f == 2) e.lane[l][63:56] = blk.chan[c][l%4][8:1];
      end
    end
    return e;
  endfunction : exp_frame

  // Lanes that carry a channel: pairs in the paired format, quads otherwise.
  function automatic logic [7:0] exp_lanes(input int f, input int m);
    exp_lanes = 8'h00;
    for (int l = 0; l < 8; l++) begin
      exp_lanes[l] = (((f == 0) ? l / 2 : l / 4) < (1 << m));
    end
  endfunction : exp_lanes

  // Holds the block up until an edge accepts it; valid stays high for back-to-back use.
  task automatic send(input int f, input int m);
    int n;
    n = 0;
    fmt <= lane_mapper_pkg::link_format_select_t'(f);
    mode <= lane_mapper_pkg::chan_mode_t'(m);
    sampleValid <= 1'b1;
    @(posedge clk);
    while (sampleReady !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    chk(sampleReady, 1'b1);
  endtask : send

  task automatic expect_frame(input lane_mapper_pkg::lane_frame_t e);
    int n;
    n = 0;
    while (rx.got.size() == 0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (rx.got.size() == 0) rx.got.push_back('x);
    chk(rx.got.pop_front(), e);
  endtask : expect_frame

  task automatic run(input int f, input int m);
    send(f, m);
    sampleValid <= 1'b0;
    expect_frame(exp_frame(f, m));
    chk(laneActive, exp_lanes(f, m));
    chk(formatRejected, 1'b0);
  endtask : run

  task automatic t_formats;
    for (int m = 0; m < 3; m++) run(0, m);
    for (int m = 0; m < 2; m++) run(1, m);
    for (int m = 0; m < 2; m++) run(2, m);
  endtask : t_formats

  task automatic t_refuse;
    int cf[4] = '{2, 1, 3, 0};
    int cm[4] = '{2, 2, 0, 3};
    logic [15:0] d0;
    d0 = droppedFrames;
    for (int i = 0; i < 4; i++) begin
      send(cf[i], cm[i]);
      sampleValid <= 1'b0;
      @(posedge clk);
      chk(formatRejected, 1'b1);
      chk(droppedFrames, d0 + 16'(i + 1));
      chk(frameValid, 1'b0);
      chk(laneActive, 8'h00);
    end
  endtask : t_refuse

  task automatic t_stall;
    stall <= 1'b1;
    send(0, 2);
    send(1, 1);
    sampleValid <= 1'b0;
    ce <= 1'b0;
    @(posedge clk);
    chk(sampleReady, 1'b0);
    ce <= 1'b1;
    @(posedge clk);
    chk(sampleReady, 1'b0);
    stall <= 1'b0;
    expect_frame(exp_frame(0, 2));
    expect_frame(exp_frame(1, 1));
  endtask : t_stall

  // Mid-run reset clears the drop count and flags, then the block maps again.
  task automatic t_reset;
    rstn <= 1'b0;
    @(posedge clk);
    chk(droppedFrames, 16'h0000);
    chk(formatRejected, 1'b0);
    chk(laneActive, 8'h00);
    chk(frameValid, 1'b0);
    rstn <= 1'b1;
    @(posedge clk);
    run(2, 0);
  endtask : t_reset

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    stall = 1'b0;
    sampleValid = 1'b0;
    fmt = lane_mapper_pkg::FMT_NINE_PAIR;
    mode = lane_mapper_pkg::CH_SINGLE;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 20; k++) begin
        blk.chan[c][k] = lane_mapper_pkg::sample_t'(c * 77 + k * 29 + 3);
      end
    end
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_formats();
    t_refuse();
    t_stall();
    t_reset();
    tally_and_finish();
  end
endmodule : testbench
